// ===== src/rx_port_irq_pkg.sv
// rx_port_irq_pkg: register offsets, field positions, masks and reset values
// for the per-port interrupt enable and status logic.
// assumes: byte-wide registers on an 8-bit register address space.
package rx_port_irq_pkg;

  // ==========================================================================
  // widths
  // ==========================================================================
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FLAG_W = 16;  // {high byte, low byte}

  // ==========================================================================
  // register offsets
  // ==========================================================================
  localparam logic [7:0] OFF_IRQ_ENABLE_HIGH = 8'hd8;
  localparam logic [7:0] OFF_IRQ_ENABLE_LOW  = 8'hd9;
  localparam logic [7:0] OFF_IRQ_STATUS_HIGH = 8'hda;
  localparam logic [7:0] OFF_IRQ_STATUS_LOW  = 8'hdb;

  // ==========================================================================
  // field positions, high registers
  // ==========================================================================
  localparam int unsigned BIT_LINK_ENCODE_ERR   = 2;
  localparam int unsigned BIT_CTRL_CHAN_SEQ_ERR = 1;
  localparam int unsigned BIT_CTRL_CHAN_CRC_ERR = 0;

  // ==========================================================================
  // field positions, low registers
  // ==========================================================================
  localparam int unsigned BIT_LINE_LENGTH_CHANGE = 6;
  localparam int unsigned BIT_LINE_COUNT_CHANGE  = 5;
  localparam int unsigned BIT_RX_BUFFER_OVERFLOW = 4;
  localparam int unsigned BIT_LINK_PARITY_ERR    = 2;
  localparam int unsigned BIT_PORT_VALID_CHANGE  = 1;
  localparam int unsigned BIT_LOCK_CHANGE        = 0;

  // ==========================================================================
  // masks and reset values
  // ==========================================================================
  localparam logic [7:0] HIGH_ENABLE_WR_MASK = 8'h07;  // bits 7:3 read-only zero
  localparam logic [7:0] LOW_ENABLE_WR_MASK  = 8'hff;  // reserved bits writable
  localparam logic [7:0] HIGH_STATUS_MASK    = 8'h07;
  localparam logic [7:0] LOW_STATUS_MASK     = 8'h77;
  localparam logic [7:0] HIGH_CLR_BY_FIRST   = 8'h03;  // seq, crc
  localparam logic [7:0] LOW_CLR_BY_FIRST    = 8'h07;  // parity, valid, lock
  localparam logic [7:0] HIGH_CLR_BY_SECOND  = 8'h04;  // encode
  localparam logic [7:0] LOW_CLR_BY_SECOND   = 8'h70;  // length, count, overflow
  localparam logic [7:0] ENABLE_RESET        = 8'h00;
  localparam logic [7:0] STATUS_RESET        = 8'h00;
  localparam logic [7:0] UNMAPPED_READ       = 8'h00;

endpackage

// ===== src/flag_bank_if.sv
// flag_bank_if: carries set, clear and flag vectors between the port
// interrupt logic and its sticky flag bank.
// assumes: both ends on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface flag_bank_if #(
  parameter int unsigned W = 16
);
  logic [W-1:0] set;
  logic [W-1:0] clr;
  logic [W-1:0] flags;

  modport bank (input set, input clr, output flags);
  modport user (output set, output clr, input flags);
endinterface
`default_nettype wire

// ===== src/sticky_flag_bank.sv
// sticky_flag_bank: a row of sticky flags, set by hardware, cleared by pulses.
// assumes: synchronous active-high reset, set and clear are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module sticky_flag_bank
  import rx_port_irq_pkg::*;
#(
  parameter int unsigned W = 16
) (
  input  wire logic i_clk_sys,
  input  wire logic i_sys_rst,
  flag_bank_if.bank fb
);

  logic [W-1:0] flag_q;

  // ==========================================================================
  // one flop per flag; a set in the clear cycle wins
  // ==========================================================================
  for (genvar g = 0; g < W; g++) begin : g_flag
    logic flag_d;
    assign flag_d = fb.set[g] | (flag_q[g] & ~fb.clr[g]);
    always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
        flag_q[g] <= 1'b0;
      end else begin
        flag_q[g] <= flag_d;
      end
    end
  end

  assign fb.flags = flag_q;

endmodule
`default_nettype wire

// ===== src/rx_port_interrupt_logic.sv
// rx_port_interrupt_logic: per receive port interrupt enable and status.
// assumes: event inputs are one-cycle pulses from the port's detectors,
// synchronous to i_clk_sys; the port status register reads are reported
// by the register block as one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// R1: with high enable bit 2 set, a link encoding error raises the interrupt.
// R2: with high enable bit 1 set, a control-channel sequence error raises the interrupt.
// R3: with high enable bit 0 set, a control-channel crc error raises the interrupt.
// R4: with low enable bit 6 set, a video line length change raises the interrupt.
// R5: with low enable bit 5 set, a change in lines per frame raises the interrupt.
// R6: with low enable bit 4 set, a receive buffer overflow raises the interrupt.
// R7: with low enable bit 2 set, a link parity error raises the interrupt.
// R8: with low enable bit 1 set, a port valid status change raises the interrupt.
// R9: with low enable bit 0 set, a lock status change raises the interrupt.
// R10: high status bit 2 latches encoding errors and clears on a second port status read.
// R11: high status bits 1 and 0 latch sequence and crc errors and clear on a first port status read.
// R12: low status bits 6, 5 and 4 latch length, count and overflow and clear on a second port status read.
// R13: low status bit 2 latches parity errors and clears on a first port status read.
// R14: low status bit 1 latches port valid changes and clears on a first port status read.
// R15: low status bit 0 latches lock changes and clears on a first port status read.
// R16: the interrupt is high one cycle after any status bit and its enable are both set, and drops one cycle after they are not; enables reset to off.
module rx_port_interrupt_logic
  import rx_port_irq_pkg::*;
(
  input  wire logic              i_clk_sys,
  input  wire logic              i_sys_rst,
  input  wire logic [ADDR_W-1:0] i_reg_addr,
  input  wire logic              i_reg_wr_en,
  input  wire logic [DATA_W-1:0] i_reg_wr_data,
  input  wire logic              i_reg_rd_en,
  output logic      [DATA_W-1:0] o_reg_rd_data,
  output logic                   o_reg_rd_valid,
  input  wire logic              i_port_status_first_rd,
  input  wire logic              i_port_status_second_rd,
  input  wire logic              i_link_encode_err,
  input  wire logic              i_ctrl_chan_seq_err,
  input  wire logic              i_ctrl_chan_crc_err,
  input  wire logic              i_line_length_change,
  input  wire logic              i_line_count_change,
  input  wire logic              i_rx_buffer_overflow,
  input  wire logic              i_link_parity_err,
  input  wire logic              i_port_valid_change,
  input  wire logic              i_lock_change,
  output logic                   o_port_irq
);

  // ==========================================================================
  // decode helper
  // ==========================================================================
  // true when an access strobe targets the given offset
  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] off,
                                    input logic              strobe);
    addr_hit = strobe & (addr == off);
  endfunction

  // ==========================================================================
  // declarations
  // ==========================================================================
  logic [DATA_W-1:0] en_high_q;
  logic [DATA_W-1:0] en_high_d;
  logic [DATA_W-1:0] en_low_q;
  logic [DATA_W-1:0] en_low_d;
  logic [DATA_W-1:0] rd_data_q;
  logic [DATA_W-1:0] rd_data_d;
  logic              rd_valid_q;
  logic              irq_q;
  logic              irq_d;
  logic              wr_en_high;
  logic              wr_en_low;
  logic              rd_en_high;
  logic              rd_en_low;
  logic              rd_st_high;
  logic              rd_st_low;
  logic [DATA_W-1:0] evt_high;
  logic [DATA_W-1:0] evt_low;
  logic [DATA_W-1:0] set_high;
  logic [DATA_W-1:0] set_low;
  logic [DATA_W-1:0] clr_high;
  logic [DATA_W-1:0] clr_low;
  logic [DATA_W-1:0] st_high;
  logic [DATA_W-1:0] st_low;

  flag_bank_if #(.W(FLAG_W)) fb ();

  // ==========================================================================
  // register access decode
  // ==========================================================================
  assign wr_en_high = addr_hit(i_reg_addr, OFF_IRQ_ENABLE_HIGH, i_reg_wr_en);
  assign wr_en_low  = addr_hit(i_reg_addr, OFF_IRQ_ENABLE_LOW, i_reg_wr_en);
  assign rd_en_high = addr_hit(i_reg_addr, OFF_IRQ_ENABLE_HIGH, i_reg_rd_en);
  assign rd_en_low  = addr_hit(i_reg_addr, OFF_IRQ_ENABLE_LOW, i_reg_rd_en);
  assign rd_st_high = addr_hit(i_reg_addr, OFF_IRQ_STATUS_HIGH, i_reg_rd_en);
  assign rd_st_low  = addr_hit(i_reg_addr, OFF_IRQ_STATUS_LOW, i_reg_rd_en);

  // ==========================================================================
  // enable registers
  // ==========================================================================
  // in the high register only implemented bits take a write; reserved high bits stay zero
  assign en_high_d = wr_en_high ? (i_reg_wr_data & HIGH_ENABLE_WR_MASK) : en_high_q;
  assign en_low_d  = wr_en_low ? (i_reg_wr_data & LOW_ENABLE_WR_MASK) : en_low_q;

  // enables come out of reset disabled
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      en_high_q <= ENABLE_RESET;  // see R16
      en_low_q  <= ENABLE_RESET;  // see R16
    end else begin
      en_high_q <= en_high_d;
      en_low_q  <= en_low_d;
    end
  end

  // ==========================================================================
  // event gathering
  // ==========================================================================
  // high byte: encoding, control-channel sequence and crc errors
  always_comb begin
    evt_high = 8'h00;
    evt_high[BIT_LINK_ENCODE_ERR]   = i_link_encode_err;
    evt_high[BIT_CTRL_CHAN_SEQ_ERR] = i_ctrl_chan_seq_err;
    evt_high[BIT_CTRL_CHAN_CRC_ERR] = i_ctrl_chan_crc_err;
  end

  // low byte: video line changes, overflow, parity, valid and lock changes
  always_comb begin
    evt_low = 8'h00;
    evt_low[BIT_LINE_LENGTH_CHANGE] = i_line_length_change;
    evt_low[BIT_LINE_COUNT_CHANGE]  = i_line_count_change;
    evt_low[BIT_RX_BUFFER_OVERFLOW] = i_rx_buffer_overflow;
    evt_low[BIT_LINK_PARITY_ERR]    = i_link_parity_err;
    evt_low[BIT_PORT_VALID_CHANGE]  = i_port_valid_change;
    evt_low[BIT_LOCK_CHANGE]        = i_lock_change;
  end

  // ==========================================================================
  // set and clear vectors for the flag bank
  // ==========================================================================
  // only enabled events latch
  assign set_high = evt_high & en_high_q & HIGH_STATUS_MASK;  // see R1 R2 R3
  assign set_low  = evt_low & en_low_q & LOW_STATUS_MASK;  // see R4 R5 R6 R7 R8 R9

  // each flag clears on the read of the port status register that reports it
  assign clr_high = ({DATA_W{i_port_status_first_rd}} & HIGH_CLR_BY_FIRST)    // see R11
                  | ({DATA_W{i_port_status_second_rd}} & HIGH_CLR_BY_SECOND); // see R10
  assign clr_low  = ({DATA_W{i_port_status_first_rd}} & LOW_CLR_BY_FIRST)      // see R13 R14 R15
                  | ({DATA_W{i_port_status_second_rd}} & LOW_CLR_BY_SECOND);  // see R12

  assign fb.set = {set_high, set_low};
  assign fb.clr = {clr_high, clr_low};

  // unused status positions are masked so they always read zero
  assign st_high = fb.flags[FLAG_W-1:DATA_W] & HIGH_STATUS_MASK;
  assign st_low  = fb.flags[DATA_W-1:0] & LOW_STATUS_MASK;

  sticky_flag_bank #(
    .W (FLAG_W)
  ) u_flags (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .fb        (fb)
  );

  // ==========================================================================
  // interrupt request
  // ==========================================================================
  assign irq_d = |({st_high, st_low} & {en_high_q, en_low_q});  // see R16

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // ==========================================================================
  // read data path
  // ==========================================================================
  // unmapped offsets answer with zero
  assign rd_data_d = rd_en_high ? en_high_q :
                     rd_en_low  ? en_low_q  :
                     rd_st_high ? st_high   :
                     rd_st_low  ? st_low    : UNMAPPED_READ;

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      rd_data_q  <= UNMAPPED_READ;
      rd_valid_q <= 1'b0;
    end else begin
      rd_data_q  <= i_reg_rd_en ? rd_data_d : rd_data_q;
      rd_valid_q <= i_reg_rd_en;
    end
  end

  assign o_reg_rd_data  = rd_data_q;
  assign o_reg_rd_valid = rd_valid_q;
  assign o_port_irq     = irq_q;

  // ==========================================================================
  // assertions
  // ==========================================================================
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  // enabled event reaches the interrupt output two edges later
  AST_ENCODE_RAISES_IRQ: assert property ( // see R1
    en_high_q[BIT_LINK_ENCODE_ERR] && i_link_encode_err && !wr_en_high |-> ##2 o_port_irq)
    else $error("encoding error with enable did not raise interrupt");

  AST_SEQ_LATCHES: assert property ( // see R2
    en_high_q[BIT_CTRL_CHAN_SEQ_ERR] && i_ctrl_chan_seq_err |=> st_high[BIT_CTRL_CHAN_SEQ_ERR])
    else $error("sequence error with enable not latched");

  AST_CRC_LATCHES: assert property ( // see R3
    en_high_q[BIT_CTRL_CHAN_CRC_ERR] && i_ctrl_chan_crc_err && !wr_en_high |=> ##1 o_port_irq)
    else $error("crc error with enable did not raise interrupt");

  AST_LENGTH_LATCHES: assert property ( // see R4
    en_low_q[BIT_LINE_LENGTH_CHANGE] && i_line_length_change |=> st_low[BIT_LINE_LENGTH_CHANGE])
    else $error("line length change not latched");

  AST_COUNT_LATCHES: assert property ( // see R5
    en_low_q[BIT_LINE_COUNT_CHANGE] && i_line_count_change && !wr_en_low |-> ##2 o_port_irq)
    else $error("line count change did not raise interrupt");

  AST_OVERFLOW_LATCHES: assert property ( // see R6
    en_low_q[BIT_RX_BUFFER_OVERFLOW] && i_rx_buffer_overflow |=> st_low[BIT_RX_BUFFER_OVERFLOW])
    else $error("buffer overflow not latched");

  AST_PARITY_LATCHES: assert property ( // see R7
    en_low_q[BIT_LINK_PARITY_ERR] && i_link_parity_err |=> st_low[BIT_LINK_PARITY_ERR])
    else $error("parity error not latched");

  AST_VALID_LATCHES: assert property ( // see R8
    en_low_q[BIT_PORT_VALID_CHANGE] && i_port_valid_change && !wr_en_low |-> ##2 o_port_irq)
    else $error("port valid change did not raise interrupt");

  AST_LOCK_LATCHES: assert property ( // see R9
    en_low_q[BIT_LOCK_CHANGE] && i_lock_change |=> st_low[BIT_LOCK_CHANGE])
    else $error("lock change not latched");

  // a disabled lock change never latches
  AST_DISABLED_NO_SET: assert property ( // see R9
    !en_low_q[BIT_LOCK_CHANGE] && !st_low[BIT_LOCK_CHANGE] |=> !st_low[BIT_LOCK_CHANGE])
    else $error("lock flag set while disabled");

  AST_ENCODE_CLEAR: assert property ( // see R10
    st_high[BIT_LINK_ENCODE_ERR] && i_port_status_second_rd && !i_link_encode_err
      |=> !st_high[BIT_LINK_ENCODE_ERR])
    else $error("encode flag not cleared by second status read");

  AST_ENCODE_HOLDS: assert property ( // see R10
    st_high[BIT_LINK_ENCODE_ERR] && !i_port_status_second_rd |=> st_high[BIT_LINK_ENCODE_ERR])
    else $error("encode flag lost without second status read");

  AST_HIGH_FIRST_CLEAR: assert property ( // see R11
    i_port_status_first_rd && !i_ctrl_chan_seq_err && !i_ctrl_chan_crc_err
      |=> st_high[BIT_CTRL_CHAN_SEQ_ERR:BIT_CTRL_CHAN_CRC_ERR] == 2'h0)
    else $error("control channel flags not cleared by first status read");

  AST_LOW_SECOND_CLEAR: assert property ( // see R12
    i_port_status_second_rd && !i_line_length_change && !i_line_count_change && !i_rx_buffer_overflow
      |=> st_low[BIT_LINE_LENGTH_CHANGE:BIT_RX_BUFFER_OVERFLOW] == 3'h0)
    else $error("video and buffer flags not cleared by second status read");

  AST_SECOND_KEEPS_LOCK: assert property ( // see R15
    st_low[BIT_LOCK_CHANGE] && i_port_status_second_rd && !i_port_status_first_rd
      |=> st_low[BIT_LOCK_CHANGE])
    else $error("lock flag cleared by wrong status read");

  AST_PARITY_CLEAR: assert property ( // see R13
    i_port_status_first_rd && !i_link_parity_err |=> !st_low[BIT_LINK_PARITY_ERR])
    else $error("parity flag not cleared by first status read");

  AST_VALID_CLEAR: assert property ( // see R14
    i_port_status_first_rd && !i_port_valid_change |=> !st_low[BIT_PORT_VALID_CHANGE])
    else $error("valid flag not cleared by first status read");

  AST_LOCK_CLEAR_SET_WINS: assert property ( // see R15
    i_port_status_first_rd && en_low_q[BIT_LOCK_CHANGE] && i_lock_change |=> st_low[BIT_LOCK_CHANGE])
    else $error("lock event lost in its clear cycle");

  AST_IRQ_QUIET: assert property ( // see R16
    !irq_d [*2] |-> ##1 !o_port_irq)
    else $error("interrupt raised with no enabled status");

  AST_ENABLE_RESET: assert property (@(posedge i_clk_sys) disable iff (1'b0) // see R16
    $past(i_sys_rst) |-> (en_high_q == ENABLE_RESET) && (en_low_q == ENABLE_RESET) && !o_port_irq)
    else $error("enables or interrupt not cleared by reset");

  AST_STATUS_READ: assert property (
    rd_st_low |=> o_reg_rd_valid && (o_reg_rd_data == $past(st_low)))
    else $error("status low read returned wrong value");

  // flags hold until the status read that owns them
  AST_FIRST_HIGH_HOLD: assert property ( // see R11
    !i_port_status_first_rd |=> ($past(st_high) & ~st_high & HIGH_CLR_BY_FIRST) == 8'h00)
    else $error("control channel flag dropped without first read");

  AST_FIRST_LOW_HOLD: assert property ( // see R13 R14 R15
    !i_port_status_first_rd |=> ($past(st_low) & ~st_low & LOW_CLR_BY_FIRST) == 8'h00)
    else $error("parity, valid or lock flag dropped without first read");

  AST_SECOND_LOW_HOLD: assert property ( // see R12
    !i_port_status_second_rd |=> ($past(st_low) & ~st_low & LOW_CLR_BY_SECOND) == 8'h00)
    else $error("video or buffer flag dropped without second read");

  // no low flag rises unless its enable was set
  AST_LOW_SET_NEEDS_ENABLE: assert property ( // see R4 R5 R6 R7 R8 R9
    (st_low & ~$past(st_low) & ~$past(en_low_q)) == 8'h00)
    else $error("low flag rose with its enable off");

  AST_UNUSED_FLAGS_ZERO: assert property ( // see R10 R12
    (fb.flags & ~{HIGH_STATUS_MASK, LOW_STATUS_MASK}) == 16'h0000)
    else $error("unused flag position set");

  // interrupt only follows an enabled flag
  AST_IRQ_NEEDS_FLAG: assert property ( // see R16
    o_port_irq |-> $past(irq_d))
    else $error("interrupt without enabled flag");

  // register port behaviour
  AST_WRITE_LANDS_LOW: assert property (
    wr_en_low |=> en_low_q == $past(i_reg_wr_data))
    else $error("enable low write did not land");

  AST_RD_VALID_FROM_STROBE: assert property (
    o_reg_rd_valid |-> $past(i_reg_rd_en))
    else $error("read valid without read strobe");

  AST_HIGH_ENABLE_RESERVED: assert property (
    (en_high_q & ~HIGH_ENABLE_WR_MASK) == 8'h00)
    else $error("reserved enable high bit set");

  // ==========================================================================
  // covers
  // ==========================================================================
  COV_IRQ_RISE: cover property (!o_port_irq ##1 o_port_irq);
  COV_SET_IN_CLEAR: cover property (i_port_status_first_rd && i_lock_change && en_low_q[BIT_LOCK_CHANGE]);
  COV_SECOND_READ_DROPS_IRQ: cover property (o_port_irq && i_port_status_second_rd ##2 !o_port_irq);
  COV_MASKED_EVENT: cover property (i_link_parity_err && !en_low_q[BIT_LINK_PARITY_ERR]);
  COV_ENCODE_EVENT: cover property (en_high_q[BIT_LINK_ENCODE_ERR] && i_link_encode_err);

endmodule
`default_nettype wire

// ===== test/tb_rx_port_interrupt_logic.sv
// tb_rx_port_interrupt_logic: self-checking bench for the port interrupt block.
// assumes: 40 MHz clock, synchronous active-high reset, strobe register port
// with one-cycle read latency, events and clears as one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module tb_rx_port_interrupt_logic
  import rx_port_irq_pkg::*;
;
  // ==========================================================================
  // signals and tables
  // ==========================================================================
  logic              clk_sys = 1'b0;
  logic              sys_rst = 1'b1;
  logic [7:0]        reg_addr = 8'h00;
  logic              reg_wr_en = 1'b0;
  logic [7:0]        reg_wr_data = 8'h00;
  logic              reg_rd_en = 1'b0;
  logic [7:0]        reg_rd_data;
  logic              reg_rd_valid;
  logic              clr_first = 1'b0;
  logic              clr_second = 1'b0;
  logic [8:0]        ev = 9'h000;
  logic              port_irq;
  int                num_errors = 0;
  int                cmp_count = 0;
  // event order: encode, seq, crc, length, count, overflow, parity, valid, lock
  localparam logic [8:0] EV_HIGH  = 9'b000_000_111;
  localparam logic [8:0] EV_FIRST = 9'b111_000_110;
  localparam int unsigned EV_POS [9] = '{BIT_LINK_ENCODE_ERR, BIT_CTRL_CHAN_SEQ_ERR, BIT_CTRL_CHAN_CRC_ERR,
    BIT_LINE_LENGTH_CHANGE, BIT_LINE_COUNT_CHANGE, BIT_RX_BUFFER_OVERFLOW, BIT_LINK_PARITY_ERR,
    BIT_PORT_VALID_CHANGE, BIT_LOCK_CHANGE};

  // clock generation, 25 ns period
  always #12.5 clk_sys = ~clk_sys;

  rx_port_interrupt_logic i_dut (
    .i_clk_sys               (clk_sys),
    .i_sys_rst               (sys_rst),
    .i_reg_addr              (reg_addr),
    .i_reg_wr_en             (reg_wr_en),
    .i_reg_wr_data           (reg_wr_data),
    .i_reg_rd_en             (reg_rd_en),
    .o_reg_rd_data           (reg_rd_data),
    .o_reg_rd_valid          (reg_rd_valid),
    .i_port_status_first_rd  (clr_first),
    .i_port_status_second_rd (clr_second),
    .i_link_encode_err       (ev[0]),
    .i_ctrl_chan_seq_err     (ev[1]),
    .i_ctrl_chan_crc_err     (ev[2]),
    .i_line_length_change    (ev[3]),
    .i_line_count_change     (ev[4]),
    .i_rx_buffer_overflow    (ev[5]),
    .i_link_parity_err       (ev[6]),
    .i_port_valid_change     (ev[7]),
    .i_lock_change           (ev[8]),
    .o_port_irq              (port_irq)
  );

  // ==========================================================================
  // shared tasks
  // ==========================================================================
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_sys);
    reg_addr    <= addr;
    reg_wr_data <= data;
    reg_wr_en   <= 1'b1;
    @(posedge clk_sys);
    reg_wr_en   <= 1'b0;
  endtask

  // read data and valid are looked at just after the answering edge
  task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clk_sys);
    reg_addr  <= addr;
    reg_rd_en <= 1'b1;
    @(posedge clk_sys);
    reg_rd_en <= 1'b0;
    #1;
    check({7'h00, reg_rd_valid}, 8'h01, "read valid");
    data = reg_rd_data;
  endtask

  task automatic expect_reg(input logic [7:0] addr, input logic [7:0] exp, input string what);
    logic [7:0] d;
    reg_read(addr, d);
    check(d, exp, what);
  endtask

  // one-cycle pulses on events and on the port status read reports
  task automatic pulse(input logic [8:0] evs, input logic first, input logic second);
    @(posedge clk_sys);
    ev         <= evs;
    clr_first  <= first;
    clr_second <= second;
    @(posedge clk_sys);
    ev         <= 9'h000;
    clr_first  <= 1'b0;
    clr_second <= 1'b0;
    #1;
  endtask

  // ==========================================================================
  // scenarios
  // ==========================================================================
  task automatic test_reset_and_access();
    #1;
    check({7'h00, port_irq}, 8'h00, "irq after reset");
    expect_reg(OFF_IRQ_ENABLE_HIGH, 8'h00, "enable high reset");
    expect_reg(OFF_IRQ_ENABLE_LOW, 8'h00, "enable low reset");
    expect_reg(OFF_IRQ_STATUS_HIGH, 8'h00, "status high reset");
    expect_reg(OFF_IRQ_STATUS_LOW, 8'h00, "status low reset");
    reg_write(OFF_IRQ_ENABLE_HIGH, 8'hff);
    reg_write(OFF_IRQ_ENABLE_LOW, 8'hff);
    reg_write(OFF_IRQ_STATUS_HIGH, 8'hff);
    reg_write(OFF_IRQ_STATUS_LOW, 8'hff);
    reg_write(8'he0, 8'h5a);
    expect_reg(OFF_IRQ_ENABLE_HIGH, 8'h07, "enable high writable bits");
    expect_reg(OFF_IRQ_ENABLE_LOW, 8'hff, "enable low writable bits");
    expect_reg(OFF_IRQ_STATUS_HIGH, 8'h00, "status high read only");
    expect_reg(OFF_IRQ_STATUS_LOW, 8'h00, "status low read only");
    expect_reg(8'he0, 8'h00, "unmapped read");
    check({7'h00, port_irq}, 8'h00, "irq with no events");
    reg_write(OFF_IRQ_ENABLE_HIGH, 8'h00);
    reg_write(OFF_IRQ_ENABLE_LOW, 8'h00);
  endtask

  // each event alone: latch, irq timing, wrong clear ignored, right clear works
  task automatic test_each_event();
    logic [7:0] m;
    logic [7:0] sreg;
    logic [7:0] ereg;
    for (int i = 0; i < 9; i++) begin
      m    = 8'h01 << EV_POS[i];
      sreg = EV_HIGH[i] ? OFF_IRQ_STATUS_HIGH : OFF_IRQ_STATUS_LOW;
      ereg = EV_HIGH[i] ? OFF_IRQ_ENABLE_HIGH : OFF_IRQ_ENABLE_LOW;
      reg_write(ereg, m);
      pulse(9'h001 << i, 1'b0, 1'b0);
      check({7'h00, port_irq}, 8'h00, "irq one cycle after event");
      @(posedge clk_sys);
      #1;
      check({7'h00, port_irq}, 8'h01, "irq two cycles after event");
      expect_reg(sreg, m, "status latched");
      pulse(9'h000, ~EV_FIRST[i], EV_FIRST[i]);
      expect_reg(sreg, m, "status kept by other clear");
      pulse(9'h000, EV_FIRST[i], ~EV_FIRST[i]);
      check({7'h00, port_irq}, 8'h01, "irq one cycle after clear");
      expect_reg(sreg, 8'h00, "status cleared");
      check({7'h00, port_irq}, 8'h00, "irq after clear");
      reg_write(ereg, 8'h00);
    end
  endtask

  // all events with enables off are dropped
  task automatic test_disabled_dropped();
    pulse(9'h1ff, 1'b0, 1'b0);
    @(posedge clk_sys);
    #1;
    check({7'h00, port_irq}, 8'h00, "irq with enables off");
    expect_reg(OFF_IRQ_STATUS_HIGH, 8'h00, "high status with enables off");
    expect_reg(OFF_IRQ_STATUS_LOW, 8'h00, "low status with enables off");
  endtask

  // event meeting its clear keeps the flag; a later disable masks the irq only
  task automatic test_set_wins_and_mask();
    reg_write(OFF_IRQ_ENABLE_LOW, 8'h01);
    pulse(9'h100, 1'b1, 1'b0);
    expect_reg(OFF_IRQ_STATUS_LOW, 8'h01, "set wins over clear");
    check({7'h00, port_irq}, 8'h01, "irq with lock flag");
    reg_write(OFF_IRQ_ENABLE_LOW, 8'h00);
    @(posedge clk_sys);
    #1;
    check({7'h00, port_irq}, 8'h00, "irq masked by disable");
    expect_reg(OFF_IRQ_STATUS_LOW, 8'h01, "flag kept after disable");
    pulse(9'h000, 1'b1, 1'b0);
    expect_reg(OFF_IRQ_STATUS_LOW, 8'h00, "flag cleared after disable");
  endtask

  // ==========================================================================
  // verdict, watchdog and main sequence
  // ==========================================================================
  task automatic print_verdict();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // cuts a hang short well after the expected run of about 220 cycles
  initial begin
    #(25 * 20000);
    num_errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    print_verdict();
  end

  initial begin
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    test_reset_and_access();
    test_each_event();
    test_disabled_dropped();
    test_set_wins_and_mask();
    print_verdict();
  end
endmodule
`default_nettype wire
